// *** verilog/fine_scroll_pkg.sv ***
// Constants, register map and carrier types of the playfield fine scroll block.
package fine_scroll_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [1:0] ADDR_HSCROLL = 2'h0;
  localparam logic [1:0] ADDR_VSCROLL = 2'h1;
  localparam logic [1:0] ADDR_CTRL = 2'h2;
  localparam logic [1:0] ADDR_STATUS = 2'h3;
  localparam logic [3:0] HSCROLL_RST = 4'h0;
  localparam logic [3:0] VSCROLL_RST = 4'h0;
  localparam logic [1:0] CTRL_RST = 2'h0;
  // ----------------------------------------
  // Instruction fields
  // ----------------------------------------
  localparam int IR_RELOAD_BIT = 6;
  localparam int IR_VS_BIT = 5;
  localparam int IR_HS_BIT = 4;
  localparam logic [3:0] MODE_BLANK = 4'h0;
  localparam logic [3:0] MODE_JUMP = 4'h1;
  // ----------------------------------------
  // Playfield widths (ctrl field): 0 off, 1 narrow, 2 normal, 3 wide
  // ----------------------------------------
  localparam logic [1:0] PF_OFF = 2'h0;
  localparam logic [1:0] PF_NARROW = 2'h1;
  localparam logic [1:0] PF_NORMAL = 2'h2;
  localparam logic [1:0] PF_WIDE = 2'h3;
  // ----------------------------------------
  // Line timing in colour clocks and machine cycles
  // ----------------------------------------
  localparam logic [7:0] CC_LINE_LAST = 8'hE3;
  localparam logic [6:0] MC_LINE_LAST = 7'h71;
  localparam logic [6:0] MC_HALT_LAST = 7'h69;
  localparam logic [6:0] MC_RUNOVER_END = 7'h08;
  localparam logic [6:0] MC_START_NARROW = 7'h20;
  localparam logic [6:0] MC_START_NORMAL = 7'h18;
  localparam logic [6:0] MC_START_WIDE = 7'h10;
  localparam logic [7:0] CC_W_NARROW = 8'h80;
  localparam logic [7:0] CC_W_NORMAL = 8'hA0;
  localparam logic [7:0] CC_W_WIDE = 8'hC0;
  localparam logic [7:0] DISP_LAT = 8'h02;
  localparam logic [3:0] VCOUNT_MASK = 4'hF;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic [3:0] phase;
  } pf_out_t;
  typedef struct packed {
    logic halt;
    logic fetch;
    logic scan_inc;
  } dma_t;
endpackage

// *** verilog/playfield_fine_scroll.sv ***
// Fine horizontal and vertical scroll logic of a display-list playfield generator.
//
// Contract
// - Instruction bit 4 enables horizontal fine scroll for that mode line only.
// - Scrolled playfield shifts right by the 0-15 colour-clock scroll value.
// - Scroll zero shows the wider fetch windowed to requested width, no offset.
// - Same displayed width; wide lines shift in background left, garbage right.
// - Scroll widens fetch one step, narrow to normal, normal to wide.
// - DMA start slips one machine cycle per two steps of scroll value.
// - Odd value shares even DMA timing plus one colour-clock output delay.
// - Late fetches past machine cycle MC_HALT_LAST skip CPU halt yet latch and count.
// - Colour-clock resolution means high-res modes scroll in two-pixel steps.
// - Buffered data replays relative to each scan line start, allowing shear.
// - Mid-line change of scroll bit 0 shifts later output immediately.
// - Mid-line change of bits 1-3 only moves DMA start and stop.
// - Moving DMA end mid-line changes scan counter advance for the line.
// - Misaligned stop fails; fetch runs through blank into next line.
// - Blocked late wide fetches still forward whatever the bus holds.
// - Character modes fetch one cycle later relative to display.
// - Right-edge garbage is sent downstream like normal playfield data.
// - First mode line with bit 5 set starts at vertical scroll row.
// - First line with bit 5 clear ends at the vertical scroll row.
// - Vertical scroll value and row counter are 4-bit, counting modulo 16.
// - Blank lines never start a scroll or reload the scan pointer; one leaving a region ends at the scroll row.
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module playfield_fine_scroll
  import fine_scroll_pkg::*;
#(
  parameter int BUF_DEPTH = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Display list side
  input wire logic instr_valid,
  input wire logic [7:0] instruction_latch,
  input wire logic [15:0] reload_addr,
  output logic instr_req,
  // Memory side
  input wire logic [7:0] bus_data,
  output dma_t dma,
  output logic [15:0] scan_addr,
  // Downstream video chip
  output pf_out_t pf_out
);
  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function automatic logic [2:0] mode_shift(input logic [3:0] m);
    if (m == 4'h8 || m == 4'h9) begin
      return 3'h4;
    end else if (m == 4'h6 || m == 4'h7 || (m >= 4'hA && m <= 4'hC)) begin
      return 3'h3;
    end
    return 3'h2;
  endfunction
  function automatic logic [3:0] mode_last_row(input logic [7:0] ir);
    unique case (ir[3:0])
      4'h0: return {1'b0, ir[6:4]};
      4'h2, 4'h4, 4'h6: return 4'h7;
      4'h3: return 4'h9;
      4'h5, 4'h7: return 4'hF;
      4'h8, 4'h9, 4'hA: return 4'h3;
      4'hB, 4'hC: return 4'h1;
      default: return 4'h0;
    endcase
  endfunction
  function automatic logic [6:0] width_start(input logic [1:0] w);
    unique case (w)
      PF_NARROW: return MC_START_NARROW;
      PF_NORMAL: return MC_START_NORMAL;
      default: return MC_START_WIDE;
    endcase
  endfunction
  function automatic logic [7:0] width_cc(input logic [1:0] w);
    unique case (w)
      PF_NARROW: return CC_W_NARROW;
      PF_NORMAL: return CC_W_NORMAL;
      default: return CC_W_WIDE;
    endcase
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [3:0] horiz_fine_scroll_value_r;
  logic [3:0] vert_fine_scroll_value_r;
  logic [1:0] width_r;
  logic [7:0] ir_r;
  logic [7:0] ir_pend_r;
  logic pend_r;
  logic prev_vs_r;
  logic [3:0] row_r;
  logic [3:0] row_end_r;
  logic first_row_r;
  logic [7:0] hpos_r;
  logic dma_on_r;
  logic [2:0] hs_phase_r;
  logic [5:0] wr_idx_r;
  logic [6:0] start_mc_r;
  logic [7:0] start_cc_r;
  logic [7:0] buf_r [BUF_DEPTH];
  logic [7:0] dly_data_r;
  logic dly_valid_r;
  logic [3:0] dly_phase_r;

  // write, register readback one cycle after the strobe.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      horiz_fine_scroll_value_r <= HSCROLL_RST;
      vert_fine_scroll_value_r <= VSCROLL_RST;
      width_r <= CTRL_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_HSCROLL: horiz_fine_scroll_value_r <= reg_wdata[3:0];
        ADDR_VSCROLL: vert_fine_scroll_value_r <= reg_wdata[3:0];
        ADDR_CTRL: width_r <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_HSCROLL: reg_rdata <= {4'h0, horiz_fine_scroll_value_r};
        ADDR_VSCROLL: reg_rdata <= {4'h0, vert_fine_scroll_value_r};
        ADDR_CTRL: reg_rdata <= {6'h00, width_r};
        default: reg_rdata <= {2'h0, dma_on_r, prev_vs_r, row_r};
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Line timing
  // ----------------------------------------
  logic line_end;
  logic [6:0] mc;
  assign line_end = (hpos_r == CC_LINE_LAST);
  assign mc = hpos_r[7:1];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hpos_r <= 8'h00;
    end else begin
      hpos_r <= line_end ? 8'h00 : hpos_r + 8'h01;
    end
  end

  // ----------------------------------------
  // Mode line sequencing and vertical scroll
  // ----------------------------------------
  logic blank_like;
  logic vs_new;
  logic mode_done;
  assign blank_like = (ir_pend_r[3:0] == MODE_BLANK) || (ir_pend_r[3:0] == MODE_JUMP);
  assign vs_new = ir_pend_r[IR_VS_BIT] & ~blank_like;
  assign mode_done = line_end && (row_r == row_end_r);
  assign instr_req = mode_done;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ir_pend_r <= 8'h00;
      pend_r <= 1'b0;
    end else if (instr_valid) begin
      ir_pend_r <= instruction_latch;
      pend_r <= 1'b1;
    end else if (mode_done) begin
      pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ir_r <= 8'h00;
      prev_vs_r <= 1'b0;
      row_r <= 4'h0;
      row_end_r <= 4'h0;
      first_row_r <= 1'b0;
    end else if (mode_done) begin
      ir_r <= pend_r ? ir_pend_r : ir_r;
      prev_vs_r <= pend_r ? vs_new : prev_vs_r;
      first_row_r <= pend_r;
      // Entering a region starts at the scroll row; later lines start at 0.
      row_r <= (pend_r && vs_new && !prev_vs_r) ? vert_fine_scroll_value_r : 4'h0;
      // Leaving a region ends at the scroll row, even on a blank line.
      if (pend_r && !vs_new && prev_vs_r) begin
        row_end_r <= vert_fine_scroll_value_r;
      end else begin
        row_end_r <= mode_last_row(pend_r ? ir_pend_r : ir_r);
      end
    end else if (line_end) begin
      row_r <= (row_r + 4'h1) & VCOUNT_MASK;
      first_row_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Fetch geometry
  // ----------------------------------------
  logic pf_mode;
  logic hs_on;
  logic char_mode;
  logic [1:0] fetch_w;
  logic [2:0] shift;
  logic [2:0] stride_mask;
  logic [6:0] sched_start;
  logic [6:0] stop_mc;
  logic [7:0] fetch_bytes;
  logic aligned;
  logic on_stride;
  logic fetch_now;
  assign pf_mode = (ir_r[3:0] > MODE_JUMP) && (width_r != PF_OFF);
  assign hs_on = ir_r[IR_HS_BIT] & pf_mode;
  assign char_mode = (ir_r[3:0] <= 4'h7);
  // A scrolled line fetches one width step wider, wide stays wide.
  assign fetch_w = (hs_on && width_r != PF_WIDE) ? width_r + 2'h1 : width_r;
  assign shift = mode_shift(ir_r[3:0]);
  assign stride_mask = 3'((8'h01 << (shift - 3'h1)) - 8'h01);
  // Start slips by the even part of the value; character fetches one cycle later.
  assign sched_start = width_start(fetch_w)
                     + (hs_on ? {4'h0, horiz_fine_scroll_value_r[3:1]} : 7'h00)
                     + {6'h00, char_mode};
  assign fetch_bytes = width_cc(fetch_w) >> shift;
  // Stop point follows the live value, so mid-line writes move it.
  assign stop_mc = sched_start + 7'(fetch_bytes << (shift - 3'h1));
  // The established fetch pattern only stops within its line if the phase bits match.
  assign aligned = (((hs_on ? horiz_fine_scroll_value_r[3:1] : 3'h0) ^ hs_phase_r)
                   & stride_mask) == 3'h0;
  assign on_stride = hpos_r[0] && ((((mc - start_mc_r) >> 0) & {4'h0, stride_mask}) == 7'h00);
  assign fetch_now = dma_on_r && on_stride;

  // Start and stop act in the first half of a machine cycle, so the fetch half that follows
  // already sees them: the first fetch falls on the start cycle and none on the stop cycle.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dma_on_r <= 1'b0;
      hs_phase_r <= 3'h0;
      start_mc_r <= 7'h00;
      start_cc_r <= 8'h00;
    end else if (!hpos_r[0] && mc == sched_start && pf_mode) begin
      // Every row latches its own start, so replays follow the current value.
      start_mc_r <= sched_start;
      start_cc_r <= {sched_start, 1'b0};
      hs_phase_r <= hs_on ? horiz_fine_scroll_value_r[3:1] : 3'h0;
      dma_on_r <= first_row_r;
    end else if (dma_on_r && !hpos_r[0] && aligned
                 && (mc == stop_mc || (mc == MC_LINE_LAST && stop_mc > MC_LINE_LAST))) begin
      dma_on_r <= 1'b0;
    end else if (dma_on_r && !hpos_r[0] && mc == MC_RUNOVER_END && !first_row_r) begin
      // A failed stop runs on through blank and dies early in the next line.
      dma_on_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Fetch, scan counter and line buffer
  // ----------------------------------------
  always_comb begin
    dma.fetch = fetch_now;
    dma.scan_inc = fetch_now;
    dma.halt = fetch_now && (mc <= MC_HALT_LAST);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scan_addr <= 16'h0000;
    end else if (mode_done && pend_r && ir_pend_r[IR_RELOAD_BIT] && !blank_like) begin
      scan_addr <= reload_addr;
    end else if (fetch_now) begin
      scan_addr <= {scan_addr[15:12], scan_addr[11:0] + 12'h001};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_idx_r <= 6'h00;
    end else if (line_end && first_row_r) begin
      wr_idx_r <= 6'h00;
    end else if (fetch_now) begin
      wr_idx_r <= wr_idx_r + 6'h01;
    end
  end

  // Blocked late fetches still capture whatever the bus carries.
  always_ff @(posedge clk) begin
    if (fetch_now) begin
      buf_r[wr_idx_r] <= bus_data;
    end
  end

  // ----------------------------------------
  // Display window and output delay
  // ----------------------------------------
  logic [7:0] vis_lo;
  logic [7:0] vis_hi;
  logic [7:0] rel;
  logic [5:0] rd_idx;
  logic in_vis;
  logic has_data;
  logic fetched;
  logic [7:0] raw_data;
  logic [7:0] cur_data;
  logic [3:0] cur_phase;
  assign vis_lo = {width_start(width_r), 1'b0} + {7'h00, char_mode} + {7'h00, char_mode}
                + DISP_LAT;
  assign vis_hi = vis_lo + width_cc(width_r);
  assign rel = hpos_r - start_cc_r - DISP_LAT;
  assign rd_idx = 6'(rel >> shift);
  assign in_vis = pf_mode && (hpos_r >= vis_lo) && (hpos_r < vis_hi);
  // Ahead of the latched start is background; beyond the fetched data is garbage.
  assign fetched = pf_mode && (hpos_r >= start_cc_r + DISP_LAT);
  assign has_data = in_vis && fetched;
  assign raw_data = fetched ? buf_r[rd_idx] : 8'h00;
  assign cur_data = has_data ? raw_data : 8'h00;
  assign cur_phase = 4'(rel & ((8'h01 << shift) - 8'h01));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dly_data_r <= 8'h00;
      dly_valid_r <= 1'b0;
      dly_phase_r <= 4'h0;
    end else begin
      // The delayed copy is windowed afresh, so the left edge keeps its full width.
      dly_data_r <= raw_data;
      dly_valid_r <= fetched;
      dly_phase_r <= cur_phase;
    end
  end

  // The odd bit picks a one colour-clock delayed copy, live at every clock.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pf_out <= '0;
    end else if (hs_on && horiz_fine_scroll_value_r[0]) begin
      pf_out <= '{valid: dly_valid_r && in_vis, data: dly_data_r,
                  phase: dly_phase_r};
    end else begin
      pf_out <= '{valid: has_data, data: cur_data, phase: cur_phase};
    end
  end
endmodule

// *** bench/fine_scroll_asserts.sv ***
// Port-level concurrent checks for the playfield fine scroll block.
`timescale 1ns/1ps
module fine_scroll_asserts
  import fine_scroll_pkg::*;
#(
  parameter int BUF_DEPTH = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Display list side
  input wire logic instr_valid,
  input wire logic [7:0] instruction_latch,
  input wire logic [15:0] reload_addr,
  input wire logic instr_req,
  // Memory side
  input wire logic [7:0] bus_data,
  input wire dma_t dma,
  input wire logic [15:0] scan_addr,
  // Downstream
  input wire pf_out_t pf_out
);
  logic [7:0] hpos_r;
  // Colour clock within the line, restarted at reset release.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hpos_r <= 8'h00;
    end else begin
      hpos_r <= (hpos_r == CC_LINE_LAST) ? 8'h00 : hpos_r + 8'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its answer cycle");
  hs_readback_a: assert property (
    reg_wr && reg_addr == ADDR_HSCROLL ##1 !reg_wr ##1 reg_rd && reg_addr == ADDR_HSCROLL
    |=> reg_rdata == {4'h0, $past(reg_wdata[3:0], 3)})
    else $error("horizontal scroll readback wrong");
  vs_readback_a: assert property (
    reg_wr && reg_addr == ADDR_VSCROLL ##1 !reg_wr ##1 reg_rd && reg_addr == ADDR_VSCROLL
    |=> reg_rdata == {4'h0, $past(reg_wdata[3:0], 3)})
    else $error("vertical scroll readback wrong");
  halt_limit_a: assert property (dma.halt |-> dma.fetch && hpos_r[7:1] <= MC_HALT_LAST)
    else $error("halt outside the allowed machine cycles");
  fetch_odd_a: assert property (dma.fetch |-> hpos_r[0] ##1 !dma.fetch)
    else $error("fetch pulse not on one odd colour clock");
  line_end_a: assert property (instr_req |-> hpos_r == CC_LINE_LAST)
    else $error("mode line end away from the last colour clock");
  scan_fetch_a: assert property (dma.scan_inc |-> dma.fetch)
    else $error("scan step without a fetch");
  // A reload on the last clock of a mode line takes precedence over a late step.
  scan_step_a: assert property (
    dma.scan_inc && !instr_req |=> scan_addr[11:0] == $past(scan_addr[11:0]) + 12'h001)
    else $error("scan counter did not step by one");
  scan_bank_a: assert property (
    dma.scan_inc && !instr_req |=> scan_addr[15:12] == $past(scan_addr[15:12]))
    else $error("scan counter left its 4K block");
endmodule

bind playfield_fine_scroll fine_scroll_asserts #(.BUF_DEPTH(BUF_DEPTH)) chk (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_valid(instr_valid),
  .instruction_latch(instruction_latch), .reload_addr(reload_addr), .instr_req(instr_req),
  .bus_data(bus_data), .dma(dma), .scan_addr(scan_addr), .pf_out(pf_out));

// *** bench/pf_sink.sv ***
// Downstream colour chip model counting received playfield clocks per line.
`timescale 1ns/1ps
module pf_sink
  import fine_scroll_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Playfield stream and line marker
  input wire pf_out_t pf_out,
  input wire logic line_end,
  // Per-line statistics
  output int valid_cnt,
  output int first_pos,
  output int first_phase
);
  int pos;
  // Pairing is reckoned from line start only, and any byte is taken as data.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst || line_end) begin
      pos <= 0;
      valid_cnt <= 0;
      first_pos <= -1;
      first_phase <= -1;
    end else begin
      pos <= pos + 1;
      if (pf_out.valid === 1'b1) begin
        valid_cnt <= valid_cnt + 1;
        if (valid_cnt == 0) begin
          first_pos <= pos;
          first_phase <= int'(pf_out.phase);
        end
      end
    end
  end
endmodule

// *** bench/tb.sv ***
// Self-checking testbench for the playfield fine scroll block.
`timescale 1ns/1ps
module tb;
  import fine_scroll_pkg::*;
  localparam int VS = 1;
  logic clk, sys_rst, reg_wr, reg_rd, instr_valid, instr_req;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, instruction_latch, bus_data, d, r;
  logic [15:0] reload_addr, scan_addr, m_scan, l_sa;
  dma_t dma;
  pf_out_t pf_out;
  int n_errors, samples_checked, seed, hp, cyc, fcnt, scnt, hcnt, ffirst, vcnt, vfirst;
  int l_cyc, l_s, l_h, l_ff, l_v, l_fv, prev_vs, l_ph, vph;
  int fv [0:9], ph [0:9];
  logic [7:0] ins [0:9] = '{8'h4E, 8'h1E, 8'h1E, 8'h0E, 8'h70, 8'h2A, 8'h2A, 8'h0A, 8'h0E, 8'h02};
  logic [3:0] hs [0:9] = '{4'h0, 4'h4, 4'h5, 4'h5, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};

  playfield_fine_scroll #(.BUF_DEPTH(64)) uut (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .instr_valid(instr_valid), .instruction_latch(instruction_latch),
    .reload_addr(reload_addr), .instr_req(instr_req), .bus_data(bus_data), .dma(dma),
    .scan_addr(scan_addr), .pf_out(pf_out));
  pf_sink sink (.clk(clk), .sys_rst(sys_rst), .pf_out(pf_out), .line_end(instr_req),
    .valid_cnt(vcnt), .first_pos(vfirst), .first_phase(vph));

  // ----------------------------------------
  // Compare, bus and verdict tasks
  // ----------------------------------------
  task automatic cmp_cnt(input string what, input int exp, input int got);
    samples_checked++;
    if (exp != got) begin
      n_errors++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (exp !== got) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_write(input logic [1:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic reg_read(input logic [1:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge clk);
  endtask
  task automatic results;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Line model: expected timing and counts of one mode line
  // ----------------------------------------
  task automatic check_line(input int n);
    int mode, blank, hs_on, vs_on, cc, rows, bytes, fmc, halts;
    mode = ins[n][3:0];
    blank = mode < 2;
    hs_on = ins[n][4] && !blank;
    vs_on = ins[n][5] && !blank;
    cc = (mode == 14 || mode == 2) ? 4 : 8;
    rows = blank ? ins[n][6:4] + 1 : (mode == 14 ? 1 : (mode == 2 ? 8 : 4));
    if (vs_on && !prev_vs) rows = ((rows - 1 - VS) & 15) + 1;
    if (!vs_on && prev_vs) rows = VS + 1;
    bytes = blank ? 0 : (hs_on ? CC_W_WIDE : CC_W_NORMAL) / cc;
    fmc = (hs_on ? MC_START_WIDE + hs[n] / 2 : MC_START_NORMAL) + (mode < 8 && !blank);
    halts = 0;
    for (int i = 0; i < bytes; i++) halts += (fmc + i * cc / 2 <= MC_HALT_LAST);
    if (ins[n][6] && !blank) m_scan = 16'h2FE0;
    m_scan[11:0] = m_scan[11:0] + 12'(bytes);
    cmp_cnt("line_cycles", rows * 228, l_cyc);
    cmp_cnt("scan_steps", bytes, l_s);
    if (bytes > 0) cmp_cnt("first_fetch_mc", fmc, l_ff);
    cmp_cnt("halts", halts, l_h);
    cmp_cnt("shown_clocks", blank ? 0 : rows * CC_W_NORMAL, l_v);
    cmp_val("scan_addr", m_scan, l_sa);
    fv[n] = l_fv;
    ph[n] = l_ph;
    if (n == 2) cmp_cnt("odd_delay", (ph[1] + 3) % 4, l_ph);
    if (n == 2) cmp_cnt("odd_edge", fv[1], l_fv);
    if (n == 3) cmp_cnt("unscrolled_start", fv[0], l_fv);
    prev_vs = vs_on;
  endtask

  // ----------------------------------------
  // Clock, memory data and line monitor
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    bus_data <= 8'($random(seed));
    if (sys_rst) begin
      hp = 0;
    end else begin
      cyc++;
      if (dma.fetch === 1'b1 && fcnt++ == 0) ffirst = hp / 2;
      scnt += (dma.scan_inc === 1'b1);
      hcnt += (dma.halt === 1'b1);
      if (instr_req === 1'b1) begin
        {l_cyc, l_s, l_h, l_ff, l_v, l_fv, l_sa} = {cyc, scnt, hcnt, ffirst, vcnt, vfirst, scan_addr};
        l_ph = vph;
        {cyc, fcnt, scnt, hcnt} = '0;
      end
      hp = (hp == 227) ? 0 : hp + 1;
    end
  end
  initial begin
    #3_000_000;
    n_errors++;
    results();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, instr_valid, instruction_latch} = '0;
    {bus_data, m_scan, prev_vs, cyc, fcnt, scnt, hcnt, hp} = '0;
    reload_addr = 16'h2FE0;
    seed = 32'h66ad33e8;
    n_errors = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      reg_write(ADDR_HSCROLL, d);
      reg_read(ADDR_HSCROLL, r);
      cmp_val("hscroll", {12'h000, d[3:0]}, {8'h00, r});
      reg_write(ADDR_VSCROLL, ~d);
      reg_read(ADDR_VSCROLL, r);
      cmp_val("vscroll", {12'h000, ~d[3:0]}, {8'h00, r});
      reg_write(ADDR_CTRL, d);
      reg_read(ADDR_CTRL, r);
      cmp_val("ctrl", {14'h0000, d[1:0]}, {8'h00, r});
      reg_write(ADDR_STATUS, d);
      reg_read(ADDR_STATUS, r);
      cmp_val("status_top", 16'h0000, {14'h0000, r[7:6]});
    end
    reg_write(ADDR_CTRL, {6'h00, PF_NORMAL});
    reg_write(ADDR_VSCROLL, 8'(VS));
    reg_write(ADDR_HSCROLL, 8'h00);
    instr_valid <= 1'b1;
    instruction_latch <= ins[0];
    @(posedge clk);
    instr_valid <= 1'b0;
    for (int k = 1; k < 12; k++) begin
      for (int w = 0; w < 4000 && instr_req !== 1'b1; w++) @(negedge clk);
      cmp_cnt("line_end_seen", 1, int'(instr_req === 1'b1));
      @(posedge clk);
      #1;
      if (k >= 2) check_line(k - 2);
      instr_valid <= (k < 10);
      if (k < 10) instruction_latch <= ins[k];
      reg_addr <= ADDR_HSCROLL;
      reg_wdata <= {4'h0, hs[(k - 1) % 10]};
      reg_wr <= 1'b1;
      @(posedge clk);
      instr_valid <= 1'b0;
      reg_wr <= 1'b0;
      @(negedge clk);
    end
    results();
  end
endmodule
